/* File: common/pbx_consts.svh */
// offsets, field positions, reset values and sizes of the pci extension
// control bank; included by the design file
`ifndef PBX_CONSTS_SVH
`define PBX_CONSTS_SVH
`define PBX_OFF_READ_GATE 8'h94
`define PBX_OFF_RETRY_EXT 8'h98
`define PBX_OFF_BYPASS 8'ha8
`define PBX_OFF_SUBSYS 8'h9c
`define PBX_OFF_VENDOR 8'ha0
`define PBX_OFF_CLASS 8'ha4
`define PBX_OFF_INTSIG 8'h90
`define PBX_OFF_BAR0 8'h10
`define PBX_OFF_MAP_LO 8'h44
`define PBX_OFF_MAP_HI 8'h80
`define PBX_RST_READ_GATE 1'b1
`define PBX_RST_BYPASS 12'hfff
`define PBX_RST_RETRY_EXT 9'h000
`define PBX_BIT_GATE 0
`define PBX_NOM_LSB 1
`define PBX_NOM_MSB 3
`define PBX_MAX_LSB 4
`define PBX_MAX_MSB 5
`define PBX_BIT_NODEP 6
`define PBX_BIT_FULLBE 7
`define PBX_BIT_PF_EN 8
`define PBX_BIT_PF_SZ 9
`define PBX_BYP_MSB 11
`define PBX_MAP_ENTRIES 16
`define PBX_MAP_SEL_LSB 20
`define PBX_MAP_SEL_MSB 23
`define PBX_BAR0_MASK 32'hff000000
`define PBX_PF_LINES_SMALL 3'h2
`define PBX_PF_LINES_LARGE 3'h4
`define PBX_REV_EXT 8'h03
`endif

/* File: common/pbx_pkg.sv */
// types of the pci extension control bank
// assumes nothing of its surroundings
package pbx_pkg;
   typedef enum logic [1:0] {
      PBX_BYP_IDLE,
      PBX_BYP_RETRY,
      PBX_BYP_ABORT
   } pbx_byp_state_t;
endpackage

/* File: verilog/pbx_ext_ctrl.sv */
// pci extension control registers: read gate, retry extension, bypass
// limit, protected map table and identity overrides.
// assumes a local (internal bus) port and a pci configuration port, both
// single-cycle strobes on i_mclk, and a retry-timeout tick from the core.
`timescale 1ns/100ps
`default_nettype none
`include "pbx_consts.svh"
module pbx_ext_ctrl #(
   parameter logic [7:0] IF_REVISION = `PBX_REV_EXT,
   parameter logic [31:0] DEF_VENDOR_DEVICE = 32'h00000000, // arbitrary
   parameter logic [31:0] DEF_CLASS = 32'h00000000 // arbitrary
) (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_device_mode,
   // local (internal bus) configuration port
   input wire logic i_loc_wr,
   input wire logic i_loc_rd,
   input wire logic [7:0] i_loc_addr,
   input wire logic [31:0] i_loc_wdata,
   output logic [31:0] o_loc_rdata,
   output logic o_loc_rvalid,
   // pci configuration port
   input wire logic i_pci_wr,
   input wire logic i_pci_rd,
   input wire logic [7:0] i_pci_addr,
   input wire logic [31:0] i_pci_wdata,
   output logic [31:0] o_pci_rdata,
   output logic o_pci_rvalid,
   output logic o_pci_retry,
   // map lookup for bar0 hits
   input wire logic [31:0] i_bar0_addr,
   output logic [31:0] o_map_entry,
   // outbound read retry tracking
   input wire logic i_ob_read_start,
   input wire logic i_ob_read_done,
   input wire logic i_retry_tick,
   input wire logic i_write_pending,
   output logic o_write_bypass,
   output logic o_ob_read_abort,
   // controls toward the core
   output logic [2:0] o_nom_retry_hi,
   output logic [1:0] o_max_retry_hi,
   output logic o_no_dma_pio_dep,
   output logic o_force_full_read_byte_enables,
   output logic o_prefetch_en,
   output logic [2:0] o_prefetch_lines,
   output logic o_host_interrupt,
   output logic [31:0] o_subsystem_identity_value,
   output logic [31:0] o_vendor_device_override,
   output logic [31:0] o_class_code_override
);
   localparam logic HAS_EXT = (IF_REVISION >= `PBX_REV_EXT);

   logic gate_reg;
   logic [8:0] ext_reg;
   logic [11:0] byp_reg;
   logic [31:0] subsys_reg;
   logic [31:0] vendor_reg;
   logic [31:0] class_reg;
   logic intsig_reg;
   logic [31:0] bar0_reg;
   logic [31:0] map_reg [0:`PBX_MAP_ENTRIES-1];
   logic [31:0] loc_rdata_reg;
   logic loc_rvalid_reg;
   logic [31:0] pci_rdata_reg;
   logic pci_rvalid_reg;
   logic pci_retry_reg;
   pbx_pkg::pbx_byp_state_t byp_state_reg;
   pbx_pkg::pbx_byp_state_t byp_state_next;
   logic [11:0] byp_cnt_reg;
   logic [11:0] byp_cnt_next;
   logic bypass_used_reg;

   // map window test and index, shared by both ports
   function automatic logic is_map(input logic [7:0] a);
      is_map = (a >= `PBX_OFF_MAP_LO) && (a <= `PBX_OFF_MAP_HI)
         && (a[1:0] == 2'h0);
   endfunction
   function automatic logic [3:0] map_idx(input logic [7:0] a);
      logic [7:0] d;
      d = a - `PBX_OFF_MAP_LO;
      map_idx = d[5:2];
   endfunction

   // common read mux of the bank
   function automatic logic [31:0] rd_mux(input logic [7:0] a,
      input logic [31:0] m);
      rd_mux = 32'h00000000;
      case (a)
         `PBX_OFF_RETRY_EXT: begin
            rd_mux = {22'h000000, ext_reg[8:0], 1'b0};
         end
         `PBX_OFF_BYPASS: rd_mux = HAS_EXT ? {20'h00000, byp_reg} : 32'h0;
         `PBX_OFF_SUBSYS: rd_mux = subsys_reg;
         `PBX_OFF_VENDOR: rd_mux = vendor_reg;
         `PBX_OFF_CLASS: rd_mux = class_reg;
         `PBX_OFF_INTSIG: rd_mux = {31'h00000000, intsig_reg};
         `PBX_OFF_BAR0: rd_mux = bar0_reg;
         default: rd_mux = is_map(a) ? m : 32'h00000000;
      endcase
   endfunction

   // decode of the two ports
   wire loc_map_hit = is_map(i_loc_addr);
   wire [3:0] loc_map_sel = map_idx(i_loc_addr);
   wire [31:0] loc_map_word = map_reg[loc_map_sel];
   wire [3:0] pci_map_sel = map_idx(i_pci_addr);
   wire [31:0] pci_map_word = map_reg[pci_map_sel];
   wire pci_map_hit = is_map(i_pci_addr);
   wire pci_read_retry = i_pci_rd && gate_reg && i_device_mode;
   // cpu reads of config space valid only while gate set or in host mode
   wire loc_read_ok = gate_reg || !i_device_mode;
   wire [31:0] loc_rd_word = rd_mux(i_loc_addr, loc_map_word);
   // pci map reads give no defined data (zero here)
   wire [31:0] pci_rd_word = pci_map_hit ? 32'h00000000 :
      ((i_pci_addr == `PBX_OFF_SUBSYS) ? subsys_reg :
      rd_mux(i_pci_addr, pci_map_word));
   // bar0 keeps low 24 bits zero, 16 mbyte memory region
   wire [31:0] bar0_wr = i_pci_wdata & `PBX_BAR0_MASK;
   // entry picked by address bits 23:20
   wire [3:0] bar0_sel = i_bar0_addr[`PBX_MAP_SEL_MSB:`PBX_MAP_SEL_LSB];

   // local port writes, pci bar0 write and both read answers
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         gate_reg <= `PBX_RST_READ_GATE;
         ext_reg <= `PBX_RST_RETRY_EXT;
         byp_reg <= `PBX_RST_BYPASS;
         subsys_reg <= 32'h00000000;
         vendor_reg <= DEF_VENDOR_DEVICE;
         class_reg <= DEF_CLASS;
         intsig_reg <= 1'b0;
         bar0_reg <= 32'h00000000;
         loc_rdata_reg <= 32'h00000000;
         loc_rvalid_reg <= 1'b0;
         pci_rdata_reg <= 32'h00000000;
         pci_rvalid_reg <= 1'b0;
         pci_retry_reg <= 1'b0;
      end else begin
         loc_rvalid_reg <= i_loc_rd;
         pci_rvalid_reg <= i_pci_rd && !pci_read_retry;
         pci_retry_reg <= pci_read_retry;
         if (i_loc_rd) begin
            loc_rdata_reg <= loc_read_ok ? loc_rd_word : 32'h00000000;
         end
         if (i_pci_rd && !pci_read_retry) begin
            pci_rdata_reg <= pci_rd_word;
         end
         if (i_loc_wr) begin
            case (i_loc_addr)
               `PBX_OFF_READ_GATE: gate_reg <= i_loc_wdata[`PBX_BIT_GATE];
               `PBX_OFF_RETRY_EXT: begin
                  ext_reg[5:0] <= i_loc_wdata[6:1];
                  ext_reg[6] <= i_loc_wdata[`PBX_BIT_FULLBE];
                  // prefetch bits only from revision three
                  ext_reg[8:7] <= HAS_EXT ?
                     i_loc_wdata[`PBX_BIT_PF_SZ:`PBX_BIT_PF_EN] : 2'h0;
               end
               `PBX_OFF_BYPASS: begin
                  if (HAS_EXT) begin
                     byp_reg <= i_loc_wdata[`PBX_BYP_MSB:0];
                  end
               end
               // identity written from local side only
               `PBX_OFF_SUBSYS: subsys_reg <= i_loc_wdata;
               `PBX_OFF_VENDOR: begin
                  if (HAS_EXT) begin
                     vendor_reg <= i_loc_wdata;
                  end
               end
               `PBX_OFF_CLASS: begin
                  if (HAS_EXT) begin
                     class_reg <= i_loc_wdata;
                  end
               end
               `PBX_OFF_INTSIG: intsig_reg <= i_loc_wdata[0];
               default: ;
            endcase
         end
         if (i_pci_wr && (i_pci_addr == `PBX_OFF_BAR0)) begin
            bar0_reg <= bar0_wr;
         end
      end
   end

   // map table written only by local port
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         for (int k = 0; k < `PBX_MAP_ENTRIES; k++) begin
            map_reg[k] <= 32'h00000000;
         end
      end else if (i_loc_wr && loc_map_hit) begin
         map_reg[loc_map_sel] <= i_loc_wdata;
      end
   end

   // next state of the outbound read retry tracker
   always_comb begin
      byp_state_next = byp_state_reg;
      byp_cnt_next = byp_cnt_reg;
      case (byp_state_reg)
         pbx_pkg::PBX_BYP_IDLE: begin
            if (i_ob_read_start) begin
               byp_state_next = pbx_pkg::PBX_BYP_RETRY;
               byp_cnt_next = byp_reg;
            end
         end
         pbx_pkg::PBX_BYP_RETRY: begin
            if (i_ob_read_done) begin
               byp_state_next = pbx_pkg::PBX_BYP_IDLE;
            end else if (i_retry_tick) begin
               if (byp_cnt_reg <= 12'h001) begin
                  byp_state_next = pbx_pkg::PBX_BYP_ABORT;
                  byp_cnt_next = 12'h000;
               end else begin
                  byp_cnt_next = byp_cnt_reg - 12'h001;
               end
            end
         end
         pbx_pkg::PBX_BYP_ABORT: byp_state_next = pbx_pkg::PBX_BYP_IDLE;
         default: byp_state_next = pbx_pkg::PBX_BYP_IDLE;
      endcase
   end

   wire bypass_grant = (byp_state_reg == pbx_pkg::PBX_BYP_RETRY)
      && i_write_pending && !bypass_used_reg && !i_retry_tick;

   // retry tracker state, counter and bypass budget
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         byp_state_reg <= pbx_pkg::PBX_BYP_IDLE;
         byp_cnt_reg <= 12'h000;
         bypass_used_reg <= 1'b0;
      end else begin
         byp_state_reg <= byp_state_next;
         byp_cnt_reg <= byp_cnt_next;
         if (i_retry_tick || byp_state_reg != pbx_pkg::PBX_BYP_RETRY) begin
            bypass_used_reg <= 1'b0;
         end else if (bypass_grant) begin
            bypass_used_reg <= 1'b1;
         end
      end
   end

   // outputs toward the core
   assign o_loc_rdata = loc_rdata_reg;
   assign o_loc_rvalid = loc_rvalid_reg;
   assign o_pci_rdata = pci_rdata_reg;
   assign o_pci_rvalid = pci_rvalid_reg;
   assign o_pci_retry = pci_retry_reg;
   assign o_map_entry = map_reg[bar0_sel];
   assign o_write_bypass = bypass_grant;
   assign o_ob_read_abort = (byp_state_reg == pbx_pkg::PBX_BYP_ABORT);
   assign o_nom_retry_hi = ext_reg[2:0];
   assign o_max_retry_hi = ext_reg[4:3];
   assign o_no_dma_pio_dep = ext_reg[5];
   assign o_force_full_read_byte_enables = ext_reg[6];
   assign o_prefetch_en = ext_reg[7];
   assign o_prefetch_lines = ext_reg[8] ? `PBX_PF_LINES_LARGE :
      `PBX_PF_LINES_SMALL;
   assign o_host_interrupt = intsig_reg;
   assign o_subsystem_identity_value = subsys_reg;
   assign o_vendor_device_override = vendor_reg;
   assign o_class_code_override = class_reg;
endmodule // pbx_ext_ctrl
`default_nettype wire

/* File: verification/pbx_ext_ctrl_assertions.sv */
// concurrent checks on the ports of the pci extension bank
// assumes single-cycle strobes sampled on i_mclk
`timescale 1ns/100ps
`default_nettype none
module pbx_ext_ctrl_assertions (
   input wire logic i_mclk,
   input wire logic i_rst_n,
   input wire logic i_device_mode,
   input wire logic i_loc_wr,
   input wire logic i_loc_rd,
   input wire logic [7:0] i_loc_addr,
   input wire logic [31:0] i_loc_wdata,
   input wire logic [31:0] o_loc_rdata,
   input wire logic o_loc_rvalid,
   input wire logic i_pci_wr,
   input wire logic i_pci_rd,
   input wire logic [7:0] i_pci_addr,
   input wire logic [31:0] o_pci_rdata,
   input wire logic o_pci_rvalid,
   input wire logic o_pci_retry,
   input wire logic [31:0] i_bar0_addr,
   input wire logic [31:0] o_map_entry,
   input wire logic o_write_bypass,
   input wire logic o_ob_read_abort,
   input wire logic [31:0] o_subsystem_identity_value
);
   logic gate_reg;
   wire gated = gate_reg && i_device_mode;
   wire pmap = i_pci_addr >= 8'h44 && i_pci_addr <= 8'h80;
   // shadow of the read gate, set by reset
   always_ff @(posedge i_mclk or negedge i_rst_n) begin
      if (!i_rst_n) gate_reg <= 1'b1;
      else if (i_loc_wr && i_loc_addr == 8'h94) gate_reg <= i_loc_wdata[0];
   end
   default clocking @(posedge i_mclk); endclocking
   default disable iff (!i_rst_n);
   a_gated_retry: assert property (i_pci_rd && gated |=>
      o_pci_retry && !o_pci_rvalid) else $error("gated read not retried");
   a_pci_answer: assert property (i_pci_rd && !gated |=>
      o_pci_rvalid && !o_pci_retry) else $error("pci read not answered");
   a_loc_answer: assert property (i_loc_rd |=> o_loc_rvalid)
      else $error("local read not answered");
   a_cpu_read_zero: assert property (i_loc_rd && i_device_mode
      && !gate_reg |=> o_loc_rdata == 32'h0) else $error("cpu read seen");
   a_map_read_zero: assert property (i_pci_rd && pmap && !gated
      |=> o_pci_rdata == 32'h0) else $error("pci map read leaks");
   a_map_write_drop: assert property ((i_pci_wr && pmap && !i_loc_wr)
      ##1 $stable(i_bar0_addr) |-> $stable(o_map_entry))
      else $error("pci write reached map");
   a_abort_pulse: assert property (o_ob_read_abort |=>
      !o_ob_read_abort) else $error("abort longer than one cycle");
   a_bypass_once: assert property (o_write_bypass |=>
      !o_write_bypass) else $error("second bypass in interval");
   a_subsys_guard: assert property (i_pci_wr && !i_loc_wr |=>
      $stable(o_subsystem_identity_value)) else $error("pci wrote id");
endmodule // pbx_ext_ctrl_assertions
`default_nettype wire

/* File: verification/pbx_pci_host.sv */
// model of the external pci host issuing configuration cycles
// assumes strobes are taken on the rising edge of i_clk
`timescale 1ns/100ps
`default_nettype none
module pbx_pci_host (
   input wire logic i_clk,
   input wire logic [31:0] i_rdata,
   input wire logic i_rvalid,
   input wire logic i_retry,
   output logic o_wr,
   output logic o_rd,
   output logic [7:0] o_addr,
   output logic [31:0] o_wdata
);
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_addr = 8'h00;
      o_wdata = 32'h0;
   end
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(negedge i_clk);
      o_wr = 1'b1;
      o_addr = a;
      o_wdata = d;
      @(negedge i_clk);
      o_wr = 1'b0;
      o_addr = ~a; // released lines keep no stale value
      o_wdata = ~d;
   endtask
   // answer is {retry, valid, data} one cycle after the strobe
   task automatic rd(input logic [7:0] a, output logic [33:0] q);
      @(negedge i_clk);
      o_rd = 1'b1;
      o_addr = a;
      @(negedge i_clk);
      o_rd = 1'b0;
      o_addr = ~a;
      q = {i_retry, i_rvalid, i_rdata};
   endtask
endmodule // pbx_pci_host
`default_nettype wire

/* File: verification/tb_pbx_ext_ctrl.sv */
// bench of the pci extension bank driven through both config ports
// assumes the checker and the host model are compiled first
`timescale 1ns/100ps
`default_nettype none
module tb_pbx_ext_ctrl;
   logic clk, rst_n, dev, lwr, lrd, pwr, prs, lv, pv, pr, obs, obd;
   logic tick, wp, byp, abt, nd, fbe, pfe, hi;
   logic [7:0] la, pa;
   logic [31:0] lwd, pwd, lq, pq, bar, me, sub, ven, cls;
   logic [2:0] nom, pfl;
   logic [1:0] mx;
   int errors = 0;
   int checked = 0;
   pbx_ext_ctrl pbx_ext_ctrl_i (.i_mclk(clk), .i_rst_n(rst_n),
      .i_device_mode(dev), .i_loc_wr(lwr), .i_loc_rd(lrd), .i_loc_addr(la),
      .i_loc_wdata(lwd), .o_loc_rdata(lq), .o_loc_rvalid(lv),
      .i_pci_wr(pwr), .i_pci_rd(prs), .i_pci_addr(pa), .i_pci_wdata(pwd),
      .o_pci_rdata(pq), .o_pci_rvalid(pv), .o_pci_retry(pr),
      .i_bar0_addr(bar), .o_map_entry(me), .i_ob_read_start(obs),
      .i_ob_read_done(obd), .i_retry_tick(tick), .i_write_pending(wp),
      .o_write_bypass(byp), .o_ob_read_abort(abt), .o_nom_retry_hi(nom),
      .o_max_retry_hi(mx), .o_no_dma_pio_dep(nd),
      .o_force_full_read_byte_enables(fbe), .o_prefetch_en(pfe),
      .o_prefetch_lines(pfl), .o_host_interrupt(hi),
      .o_subsystem_identity_value(sub), .o_vendor_device_override(ven),
      .o_class_code_override(cls));
   pbx_pci_host host_i (.i_clk(clk), .i_rdata(pq), .i_rvalid(pv),
      .i_retry(pr), .o_wr(pwr), .o_rd(prs), .o_addr(pa), .o_wdata(pwd));
   task automatic complete_run;
      if (errors == 0 && checked > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic chk(input string n, input logic [33:0] e, g);
      checked++;
      if (g !== e) begin
         errors++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic lwt(input logic [7:0] a, input logic [31:0] d);
      @(negedge clk);
      {lwr, la, lwd} = {1'b1, a, d};
      @(negedge clk);
      lwr = 1'b0;
   endtask
   task automatic lrt(input logic [7:0] a, input logic [31:0] e, string n);
      @(negedge clk);
      {lrd, la} = {1'b1, a};
      @(negedge clk);
      lrd = 1'b0;
      chk(n, {2'b01, e}, {1'b0, lv, lq});
   endtask
   task automatic prt(input logic [7:0] a, input logic [33:0] e, string n);
      logic [33:0] q;
      host_i.rd(a, q);
      if (e[33]) q[31:0] = 32'h0; // data is not looked at on a retry
      chk(n, e, q);
   endtask
   task automatic tk;
      @(negedge clk);
      tick = 1'b1;
      @(negedge clk);
      tick = 1'b0;
   endtask
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   initial begin
      #100000;
      errors++;
      complete_run;
   end
   // reset, then register access, then the retry tracker
   initial begin
      {rst_n, dev, lwr, lrd, la, lwd} = {4'b0100, 8'h00, 32'h0};
      {bar, obs, obd, tick, wp} = {32'h0, 4'h0};
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n = 1'b1;
      lrt(8'ha8, 32'h00000fff, "bypass_rst");
      lrt(8'h94, 32'h0, "gate_rd");
      lwt(8'h9c, 32'ha5a50001);
      lrt(8'h9c, 32'ha5a50001, "subsys_loc");
      lwt(8'h90, 32'h00000001);
      chk("host_int", 34'h1, {33'h0, hi});
      lrt(8'h90, 32'h00000001, "intsig_rd");
      prt(8'h9c, {2'b10, 32'h0}, "gated_pci");
      // host mode: the gate does not hold off pci reads
      dev = 1'b0;
      prt(8'h9c, {2'b01, 32'ha5a50001}, "host_pci");
      dev = 1'b1;
      lwt(8'h98, 32'hffffffff);
      chk("ext_all", {23'h0, nom, mx, nd, fbe, pfe, pfl},
         {23'h0, 3'h7, 2'h3, 3'h7, 3'h4});
      lrt(8'h98, 32'h000003fe, "ext_rd");
      lwt(8'h98, 32'h00000112);
      chk("ext_sm", {23'h0, nom, mx, nd, fbe, pfe, pfl},
         {23'h0, 3'h1, 2'h1, 3'h1, 3'h2});
      lwt(8'h94, 32'h0);
      lwt(8'h9c, 32'h12340002);
      chk("subsys_wr", {2'b0, 32'h12340002}, {2'b0, sub});
      lrt(8'h9c, 32'h0, "cpu_gated");
      prt(8'h9c, {2'b01, 32'h12340002}, "subsys_pci");
      host_i.wr(8'h9c, 32'hdeadbeef);
      chk("subsys_keep", {2'b0, 32'h12340002}, {2'b0, sub});
      lwt(8'h44, 32'h00abc001);
      lwt(8'h80, 32'h00def001);
      chk("map0", {2'b0, 32'h00abc001}, {2'b0, me});
      bar = 32'h00f00000;
      host_i.wr(8'h80, 32'h0);
      chk("map15", {2'b0, 32'h00def001}, {2'b0, me});
      prt(8'h80, {2'b01, 32'h0}, "map_pci");
      host_i.wr(8'h10, 32'hffffffff);
      prt(8'h10, {2'b01, 32'hff000000}, "bar0");
      lwt(8'ha0, 32'h5555aaaa);
      lwt(8'ha4, 32'h0c0300aa);
      chk("vendor", {2'b0, 32'h5555aaaa}, {2'b0, ven});
      chk("class", {2'b0, 32'h0c0300aa}, {2'b0, cls});
      lwt(8'ha8, 32'h00000003);
      @(negedge clk);
      obs = 1'b1;
      @(negedge clk);
      {obs, wp} = 2'b01;
      #1; // let the combinational grant settle
      chk("byp_on", 34'h1, {33'h0, byp});
      @(negedge clk);
      chk("byp_once", 34'h0, {33'h0, byp});
      tk();
      #1; // tick just fell, grant follows combinationally
      chk("byp_next", 34'h1, {33'h0, byp});
      wp = 1'b0;
      tk();
      chk("no_abort", 34'h0, {33'h0, abt});
      tk();
      chk("abort", 34'h1, {33'h0, abt});
      obd = 1'b1;
      @(negedge clk);
      obd = 1'b0;
      complete_run;
   end
endmodule // tb_pbx_ext_ctrl
// checker on the ports of the bank
bind pbx_ext_ctrl pbx_ext_ctrl_assertions pbx_ext_ctrl_assertions_i (
   .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_device_mode(i_device_mode),
   .i_loc_wr(i_loc_wr), .i_loc_rd(i_loc_rd), .i_loc_addr(i_loc_addr),
   .i_loc_wdata(i_loc_wdata), .o_loc_rdata(o_loc_rdata),
   .o_loc_rvalid(o_loc_rvalid), .i_pci_wr(i_pci_wr), .i_pci_rd(i_pci_rd),
   .i_pci_addr(i_pci_addr), .o_pci_rdata(o_pci_rdata),
   .o_pci_rvalid(o_pci_rvalid), .o_pci_retry(o_pci_retry),
   .i_bar0_addr(i_bar0_addr), .o_map_entry(o_map_entry),
   .o_write_bypass(o_write_bypass), .o_ob_read_abort(o_ob_read_abort),
   .o_subsystem_identity_value(o_subsystem_identity_value));
`default_nettype wire
